// File: scan_pkg.sv
/*
 * Shared constants and types for the scan-cycle edge differentiator:
 * register offsets, control/status bit positions, reset values and the
 * instruction variant and opcode-class enumerations.
 * Assumes a 32-bit APB register bus with 8-bit byte addresses.
 */
package scan_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = DATA_W / 8;

    // Register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_EVCNT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ILLCNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_KNOWN  = 8'h14;

    // Field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_START_BIT  = 1;
    localparam int STAT_EN_BIT     = 0;
    localparam int STAT_FROZEN_BIT = 1;
    localparam int STAT_ILL_BIT    = 2;

    // Reset and start-of-operation values
    localparam logic CTRL_EN_RST    = 1'b1;
    localparam logic PREV_INIT_RISE = 1'b1;
    localparam logic PREV_INIT_FALL = 1'b0;

    typedef enum logic [1:0] {VAR_NONE, VAR_RISE, VAR_FALL} variant_t;
    typedef enum logic [2:0] {
        OP_LOAD, OP_AND, OP_OR, OP_SET, OP_BIT_RESET, OP_OTHER
    } opclass_t;

    // Differentiated variants keep a previous-value flag
    function automatic logic isDiff(variant_t v);
        return (v == VAR_RISE) || (v == VAR_FALL);
    endfunction

    // Falling variant only exists on a few basic instructions
    function automatic logic fallAllowed(opclass_t op);
        return (op == OP_LOAD) || (op == OP_AND) || (op == OP_OR)
            || (op == OP_SET) || (op == OP_BIT_RESET);
    endfunction
endpackage

// File: reg_if.sv
/*
 * Internal register access channel between the APB port and the
 * register file in the top module.
 * Assumes one clock domain; rdata and known are combinational.
 */
`timescale 1ns/100ps
interface reg_if #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 8
);
    logic              wrEn;   // Write takes effect this edge
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
    logic [DATA_W/8-1:0] wstrb; // Byte enables
    logic [DATA_W-1:0] rdata;  // Read data for addr
    logic              known;  // addr is mapped

    modport bus  (output wrEn, addr, wdata, wstrb, input rdata, known);
    modport regs (input wrEn, addr, wdata, wstrb, output rdata, known);
endinterface

// File: apb_reg_port.sv
/*
 * APB slave front end: no wait states, registered answer.
 * Assumes psel/penable follow APB; the register file answers
 * rdata and known combinationally from the address.
 */
`timescale 1ns/100ps
module apb_reg_port
    import scan_pkg::*;
(
    input  logic                        core_clk, // System clock
    input  logic                        rst,      // Sync reset
    input  logic                        psel,     // Slave select
    input  logic                        penable,  // Access phase
    input  logic                        pwrite,   // Write direction
    input  logic [scan_pkg::ADDR_W-1:0] paddr,    // Byte address
    input  logic [scan_pkg::DATA_W-1:0] pwdata,   // Write data
    input  logic [scan_pkg::STRB_W-1:0] pstrb,    // Byte enables
    output logic [scan_pkg::DATA_W-1:0] prdata,   // Read data
    output logic                        pready,   // Access done
    output logic                        pslverr,  // Unmapped address
    reg_if.bus                          rb        // To register file
);
    wire setupPh  = psel & ~penable;
    wire accessPh = psel & penable & pready;

    // Writes land only at the completing access edge
    assign rb.addr  = paddr;
    assign rb.wdata = pwdata;
    assign rb.wstrb = pstrb;
    assign rb.wrEn  = accessPh & pwrite & rb.known;

    // Answer captured in setup so every APB output is a flop
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPh;
            prdata  <= (setupPh & ~pwrite) ? rb.rdata : '0;
            pslverr <= setupPh & ~rb.known;
        end
    end
endmodule // apb_reg_port

// File: edge_eval.sv
/*
 * Combinational execution-condition evaluator for one instruction.
 * Assumes prev already holds the start-of-operation default when the
 * slot has not been evaluated since start.
 */
`timescale 1ns/100ps
module edge_eval
    import scan_pkg::*;
(
    input  scan_pkg::variant_t variant,  // Differentiation variant
    input  logic               isOutput, // Output instruction
    input  logic               invert,   // Negated input form
    input  logic               cond,     // Present condition/result
    input  logic               prev,     // Previous-value flag
    output logic               result    // Execute or power flow
);
    wire risen  = cond & ~prev;
    wire fallen = ~cond & prev;
    wire rawHit = (variant == VAR_RISE) ? risen
                : (variant == VAR_FALL) ? fallen
                : cond;
    // Negation only applies to input forms
    assign result = rawHit ^ (invert & ~isOutput);
endmodule // edge_eval

// File: scan_edge_differentiator.sv
/*
 * Scan-cycle execution-condition logic: per-instruction differentiation
 * with previous-value flags, interlock/jump freeze, immediate refresh
 * strobes and an APB register file for control and observation.
 * Assumes the scan sequencer presents one instruction per evalReq pulse,
 * all inputs synchronous to core_clk, and asserts startOp at the start
 * of operation.
 */
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module scan_edge_differentiator
    import scan_pkg::*;
#(
    parameter int NUM_SLOTS = 32,              // Differentiated slots
    parameter int OPADDR_W  = 16,              // Operand word address
    parameter int SLOT_W    = $clog2(NUM_SLOTS)
)
(
    input  logic                        core_clk,    // System clock
    input  logic                        rst,         // Sync reset, high
    // APB register port
    input  logic                        psel,        // Slave select
    input  logic                        penable,     // Access phase
    input  logic                        pwrite,      // Write direction
    input  logic [scan_pkg::ADDR_W-1:0] paddr,       // Byte address
    input  logic [scan_pkg::DATA_W-1:0] pwdata,      // Write data
    input  logic [scan_pkg::STRB_W-1:0] pstrb,       // Byte enables
    output logic [scan_pkg::DATA_W-1:0] prdata,      // Read data
    output logic                        pready,      // Access done
    output logic                        pslverr,     // Unmapped address
    // Scan sequencer request
    input  logic                        startOp,     // Start of operation
    input  logic                        evalReq,     // Evaluate one instr
    input  logic [SLOT_W-1:0]           evalSlot,    // Flag slot index
    input  scan_pkg::variant_t          evalVariant, // Differentiation
    input  scan_pkg::opclass_t          evalOpClass, // Instruction class
    input  logic                        evalRefresh, // Immediate refresh
    input  logic                        evalIsOutput,// Output instruction
    input  logic                        evalInvert,  // Negated input form
    input  logic                        evalCond,    // Condition/result
    input  logic                        evalFrozen,  // Interlock or jump
    input  logic [OPADDR_W-1:0]         evalOperand, // Operand word
    // Result to the sequencer
    output logic                        resValid,    // Result pulse
    output logic                        resExec,     // Output executes
    output logic                        resCond,     // Input power flow
    output logic                        resIllegal,  // Variant refused
    output logic                        refreshIn,   // Refresh source I/O
    output logic                        refreshOut,  // Refresh dest I/O
    output logic [OPADDR_W-1:0]         refreshAddr  // Word to refresh
);
    import scan_pkg::*;

    // Register channel from the APB front end
    reg_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) rb ();

    // Per-slot memory: flag value and whether written since start
    logic [NUM_SLOTS-1:0] prevFlag_q;
    logic [NUM_SLOTS-1:0] prevKnown_q;

    // Control and status state
    logic                 ctrlEn_q;
    logic                 ctrlStart_q;
    logic                 lastFrozen_q;
    logic                 illSeen_q;
    logic [DATA_W-1:0]    evalCount_q;
    logic [DATA_W-1:0]    illCount_q;

    // Result flops; all but refreshPend_q feed the outputs directly
    logic                 resValid_q;
    logic                 resExec_q;
    logic                 resCond_q;
    logic                 resIllegal_q;
    logic                 refreshIn_q;
    logic                 refreshOut_q;
    logic                 refreshPend_q;
    logic [OPADDR_W-1:0]  refreshAddr_q;

    // Start of operation from the pin or from software
    wire initStart = startOp | ctrlStart_q;

    // An evaluation is dropped while start-of-operation is in progress
    wire take = evalReq & ctrlEn_q & ~initStart;

    // Variant decode
    wire diffSel    = isDiff(evalVariant);
    wire illegalSel = (evalVariant == VAR_FALL)
                    & ~fallAllowed(evalOpClass);
    wire refreshSel = evalRefresh;

    // Flag lookup for the addressed slot
    wire prevRaw   = prevFlag_q[evalSlot];
    wire prevKnown = prevKnown_q[evalSlot];

    // Unwritten slots read as the start-of-operation default
    wire prevInit = (evalVariant == VAR_RISE) ? PREV_INIT_RISE
                                              : PREV_INIT_FALL;
    wire prevEff  = prevKnown ? prevRaw : prevInit;

    // Condition evaluation for the present instruction
    logic evalResult;

    edge_eval u_eval (
        .variant  (evalVariant),
        .isOutput (evalIsOutput),
        .invert   (evalInvert),
        .cond     (evalCond),
        .prev     (prevEff),
        .result   (evalResult)
    );

    // A frozen or refused instruction neither runs nor moves its flag
    wire runs       = take & ~evalFrozen & ~illegalSel;
    wire updatePrev = runs & diffSel;
    wire execNow    = runs & evalIsOutput & evalResult;
    wire condNow    = runs & ~evalIsOutput & evalResult;
    wire illNow     = take & illegalSel;

    // Software access decode
    wire selCtrl   = rb.addr == OFF_CTRL;
    wire selStatus = rb.addr == OFF_STATUS;
    wire selEvCnt  = rb.addr == OFF_EVCNT;
    wire selIllCnt = rb.addr == OFF_ILLCNT;
    wire selFlags  = rb.addr == OFF_FLAGS;
    wire selKnown  = rb.addr == OFF_KNOWN;
    wire ctrlWr    = rb.wrEn & selCtrl & rb.wstrb[0];

    // Read-side views; slots beyond one word are not visible
    wire [DATA_W-1:0] ctrlWord   = DATA_W'(ctrlEn_q) << CTRL_EN_BIT;
    wire [DATA_W-1:0] statusWord = (DATA_W'(ctrlEn_q) << STAT_EN_BIT)
                                 | (DATA_W'(lastFrozen_q)
                                    << STAT_FROZEN_BIT)
                                 | (DATA_W'(illSeen_q) << STAT_ILL_BIT);
    wire [DATA_W-1:0] flagsWord  = DATA_W'(prevFlag_q);
    wire [DATA_W-1:0] knownWord  = DATA_W'(prevKnown_q);

    assign rb.known = selCtrl | selStatus | selEvCnt | selIllCnt
                    | selFlags | selKnown;
    assign rb.rdata = selCtrl   ? ctrlWord
                    : selStatus ? statusWord
                    : selEvCnt  ? evalCount_q
                    : selIllCnt ? illCount_q
                    : selFlags  ? flagsWord
                    : selKnown  ? knownWord
                    : '0;

    // APB slave front end
    apb_reg_port u_apb (
        .core_clk (core_clk),
        .rst      (rst),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .pstrb    (pstrb),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .rb       (rb.bus)
    );

    // Control register; start bit is a self-clearing one-cycle pulse
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrlEn_q    <= CTRL_EN_RST;
            ctrlStart_q <= 1'b0;
        end
        else
        begin
            if (ctrlWr)
                ctrlEn_q <= rb.wdata[CTRL_EN_BIT];
            ctrlStart_q <= ctrlWr & rb.wdata[CTRL_START_BIT];
        end
    end

    // Previous-value flags. Start clears the flags and the known bits, so
    // each slot picks its own default by variant on first use,
    // which avoids a spurious pulse in the first scan.
    always_ff @(posedge core_clk)
    begin
        if (rst || initStart)
        begin
            prevFlag_q  <= '0;
            prevKnown_q <= '0;
        end
        else if (updatePrev)
        begin
            prevFlag_q[evalSlot]  <= evalCond;
            prevKnown_q[evalSlot] <= 1'b1;
        end
    end

    // Result strobes to the sequencer, one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            resValid_q   <= 1'b0;
            resExec_q    <= 1'b0;
            resCond_q    <= 1'b0;
            resIllegal_q <= 1'b0;
        end
        else
        begin
            resValid_q   <= take;
            resExec_q    <= execNow;
            resCond_q    <= condNow;
            resIllegal_q <= illNow;
        end
    end

    // Immediate refresh: sources before execution, destinations after.
    // Source refresh cannot precede evalCond here; the sequencer must
    // re-sample when it sees refreshIn if it needs fresh inputs.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            refreshIn_q   <= 1'b0;
            refreshPend_q <= 1'b0;
            refreshOut_q  <= 1'b0;
            refreshAddr_q <= '0;
        end
        else
        begin
            refreshIn_q   <= runs & refreshSel;
            refreshPend_q <= execNow & refreshSel;
            refreshOut_q  <= refreshPend_q;
            if (take)
                refreshAddr_q <= evalOperand;
        end
    end

    // Observation counters and status; a refused variant's set outranks the
    // start-of-operation clear, though a refused variant is dropped while start is active
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            evalCount_q  <= '0;
            illCount_q   <= '0;
            illSeen_q    <= 1'b0;
            lastFrozen_q <= 1'b0;
        end
        else
        begin
            if (take)
                evalCount_q <= evalCount_q + DATA_W'(1);
            if (illNow)
                illCount_q <= illCount_q + DATA_W'(1);
            if (illNow)
                illSeen_q <= 1'b1;
            else if (initStart)
                illSeen_q <= 1'b0;
            if (take)
                lastFrozen_q <= evalFrozen;
        end
    end

    // Outputs straight from flops
    assign resValid    = resValid_q;
    assign resExec     = resExec_q;
    assign resCond     = resCond_q;
    assign resIllegal  = resIllegal_q;
    assign refreshIn   = refreshIn_q;
    assign refreshOut  = refreshOut_q;
    assign refreshAddr = refreshAddr_q;
endmodule // scan_edge_differentiator

// File: scan_edge_monitor.sv
/* Port checks for the scan edge differentiator.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module scan_edge_monitor
    import scan_pkg::*;
(
    input logic               core_clk,     // Clock
    input logic               rst,          // Reset
    input logic               psel,         // Select
    input logic               penable,      // Access
    input logic               pready,       // Done
    input logic               startOp,      // Start
    input logic               evalReq,      // Request
    input scan_pkg::variant_t evalVariant,  // Variant
    input scan_pkg::opclass_t evalOpClass,  // Class
    input logic               evalRefresh,  // Refresh form
    input logic               evalIsOutput, // Output form
    input logic               evalInvert,   // Negated form
    input logic               evalCond,     // Condition
    input logic               evalFrozen,   // Frozen
    input logic               resValid,     // Result
    input logic               resExec,      // Execute
    input logic               resCond,      // Power flow
    input logic               resIllegal,   // Refused
    input logic               refreshOut    // Out refresh
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Plain output forms pass the condition straight through; plain input forms apply evalInvert
    property p_plainOut;
        $past(evalReq && evalVariant == VAR_NONE && evalIsOutput
            && !evalFrozen) && resValid |-> resExec == $past(evalCond);
    endproperty
    a_plainOut: assert property (p_plainOut) else $error("plain out");
    property p_plainIn;
        $past(evalReq && evalVariant == VAR_NONE && !evalIsOutput
            && !evalFrozen) && resValid
            |-> resCond == $past(evalCond ^ evalInvert);
    endproperty
    a_plainIn: assert property (p_plainIn) else $error("plain in");
    // A low condition can never make a rising edge
    property p_riseLow;
        $past(evalReq && evalVariant == VAR_RISE && !evalCond
            && !evalFrozen) && resValid
            |-> !resExec && resCond == $past(!evalIsOutput && evalInvert);
    endproperty
    a_riseLow: assert property (p_riseLow) else $error("rise low");
    property p_fallHigh;
        $past(evalReq && evalVariant == VAR_FALL && evalCond
            && !evalFrozen && evalOpClass != OP_OTHER) && resValid
            |-> !resExec && resCond == $past(!evalIsOutput && evalInvert);
    endproperty
    a_fallHigh: assert property (p_fallHigh) else $error("fall hi");
    property p_illegal;
        $past(evalReq && evalVariant == VAR_FALL && evalOpClass == OP_OTHER)
            && resValid |-> resIllegal && !resExec;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal");
    property p_frozen;
        $past(evalReq && evalFrozen) && resValid |-> !resExec && !resCond;
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen");
    property p_start;
        $past(startOp) |-> !resValid;
    endproperty
    a_start: assert property (p_start) else $error("start drop");
    property p_resSrc;
        resExec || resCond || resIllegal |-> resValid;
    endproperty
    a_resSrc: assert property (p_resSrc) else $error("no valid");
    // Output refresh trails the execute pulse by one cycle
    property p_refOut;
        refreshOut |-> $past(resExec) && $past(evalRefresh, 2)
            && $past(evalIsOutput, 2);
    endproperty
    a_refOut: assert property (p_refOut) else $error("refresh out");
    property p_apb;
        pready |-> $past(psel && !penable) ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb ready");
endmodule // scan_edge_monitor

bind scan_edge_differentiator scan_edge_monitor i_scan_edge_monitor (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .startOp(startOp), .evalReq(evalReq),
    .evalVariant(evalVariant), .evalOpClass(evalOpClass),
    .evalRefresh(evalRefresh), .evalIsOutput(evalIsOutput),
    .evalInvert(evalInvert), .evalCond(evalCond),
    .evalFrozen(evalFrozen), .resValid(resValid), .resExec(resExec),
    .resCond(resCond), .resIllegal(resIllegal), .refreshOut(refreshOut)
);

// File: seq_model.sv
/* Scan sequencer model: one instruction per call.
   Assumes the caller paces calls on clock edges. */
`timescale 1ns/100ps
module seq_model
    import scan_pkg::*;
(
    input  logic               core_clk,     // Clock
    output logic               startOp,      // Start pulse
    output logic               evalReq,      // Request
    output logic [4:0]         evalSlot,     // Flag slot
    output scan_pkg::variant_t evalVariant,  // Variant
    output scan_pkg::opclass_t evalOpClass,  // Class
    output logic               evalRefresh,  // Refresh form
    output logic               evalIsOutput, // Output form
    output logic               evalInvert,   // Negated form
    output logic               evalCond,     // Condition
    output logic               evalFrozen,   // Interlock or jump
    output logic [15:0]        evalOperand   // Operand word
);
    // Quiet at time zero
    initial
    begin
        {startOp, evalReq, evalSlot, evalRefresh, evalIsOutput} = '0;
        {evalInvert, evalCond, evalFrozen, evalOperand} = '0;
        evalVariant = VAR_NONE;
        evalOpClass = OP_LOAD;
    end

    // Launch just after an edge; idle slots still carry noise
    task automatic issue(input logic st, rq, input logic [4:0] s,
        input variant_t v, input opclass_t op,
        input logic rf, o, inv, c, fz, input logic [15:0] a);
        @(posedge core_clk);
        startOp      <= st;
        evalReq      <= rq;
        evalSlot     <= s;
        evalVariant  <= v;
        evalOpClass  <= op;
        evalRefresh  <= rf;
        evalIsOutput <= o;
        evalInvert   <= inv;
        evalCond     <= c;
        evalFrozen   <= fz;
        evalOperand  <= a;
    endtask
endmodule // seq_model

// File: tb_top.sv
/* Self-checking bench: random scan traffic against a reference model.
   Assumes the monitor and sequencer model are compiled first. */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value at %0t: %0h vs %0h", \
    $time, g, e); end end
module tb_top;
    import scan_pkg::*;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, prevV = 0, knownV = 0;
    logic        pready, pslverr, er, startOp, evalReq, evalRefresh;
    logic        evalIsOutput, evalInvert, evalCond, evalFrozen;
    logic [4:0]  evalSlot;
    logic [15:0] evalOperand, refreshAddr, expAddr = 0;
    variant_t    evalVariant;
    opclass_t    evalOpClass;
    logic        resValid, resExec, resCond, resIllegal;
    logic        refreshIn, refreshOut;
    logic [20:0] qr[$];
    logic        qo[$];
    bit          en = 1, illS = 0, lastFz = 0;
    int          evCnt = 0, illCnt = 0, error_cnt = 0, total_checks = 0;

    always #5 core_clk = ~core_clk;

    scan_edge_differentiator i_scan_edge_differentiator (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .startOp(startOp), .evalReq(evalReq), .evalSlot(evalSlot),
        .evalVariant(evalVariant), .evalOpClass(evalOpClass),
        .evalRefresh(evalRefresh), .evalIsOutput(evalIsOutput),
        .evalInvert(evalInvert), .evalCond(evalCond),
        .evalFrozen(evalFrozen), .evalOperand(evalOperand),
        .resValid(resValid), .resExec(resExec), .resCond(resCond),
        .resIllegal(resIllegal), .refreshIn(refreshIn),
        .refreshOut(refreshOut), .refreshAddr(refreshAddr));
    seq_model i_seq_model (
        .core_clk(core_clk), .startOp(startOp), .evalReq(evalReq),
        .evalSlot(evalSlot), .evalVariant(evalVariant),
        .evalOpClass(evalOpClass), .evalRefresh(evalRefresh),
        .evalIsOutput(evalIsOutput), .evalInvert(evalInvert),
        .evalCond(evalCond), .evalFrozen(evalFrozen),
        .evalOperand(evalOperand));

    // APB master; holds the request until pready is seen, giving up after 20 cycles
    task automatic apb(input bit w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) error_cnt++;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0, rd, er);
        `CHK(({er, rd}), ({1'b0, e}))
    endtask

    // Random back-to-back traffic, compared one and two cycles later
    task automatic run(input int n, input bit st);
        bit rq, o, inv, c, fz, rf, acc, ill, pv, r, s0;
        int s;
        variant_t v;
        opclass_t op;
        logic [15:0] a;
        qr.delete();
        qo.delete();
        for (int i = 0; i < n; i++)
        begin
            s0 = st && i == 0;
            rq = (i < n - 2) && ($urandom % 4 != 0);
            s = $urandom % 4;
            v = variant_t'($urandom % 3);
            op = opclass_t'($urandom % 6);
            {o, inv, c, rf} = 4'($urandom);
            fz = ($urandom % 8 == 0);
            a = 16'($urandom);
            i_seq_model.issue(s0, rq, 5'(s), v, op, rf, o, inv, c, fz, a);
            acc = rq && en && !s0;
            ill = acc && v == VAR_FALL && op == OP_OTHER;
            pv = knownV[s] ? prevV[s] : (v == VAR_RISE);
            r = v == VAR_NONE ? c : v == VAR_RISE ? c && !pv : !c && pv;
            r = (r ^ (inv && !o)) && acc && !fz && !ill;
            if (acc)
            begin
                expAddr = a;
                evCnt++;
                lastFz = fz;
            end
            if (acc && v != VAR_NONE && !fz && !ill)
            begin
                prevV[s] = c;
                knownV[s] = 1;
            end
            if (ill)
            begin
                illCnt++;
                illS = 1;
            end
            if (s0)
            begin
                prevV = 0;
                knownV = 0;
                illS = 0;
            end
            qr.push_back({expAddr, acc, r && o, r && !o, ill,
                acc && rf && !fz && !ill});
            qo.push_back(r && o && rf);
            #1;
            if (qr.size() > 1) `CHK(({refreshAddr, resValid, resExec, resCond, resIllegal, refreshIn}), qr.pop_front())
            if (qo.size() > 2) `CHK(refreshOut, qo.pop_front())
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run length
    initial
    begin
        #100000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'h3ceb));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(OFF_CTRL, 32'h1);
        run(400, 0);
        rdchk(OFF_EVCNT, evCnt);
        rdchk(OFF_ILLCNT, illCnt);
        rdchk(OFF_STATUS, {29'h0, illS, lastFz, en});
        rdchk(OFF_FLAGS, prevV);
        rdchk(OFF_KNOWN, knownV);
        apb(0, 8'h18, 0, rd, er);
        `CHK(({er, rd}), 33'h100000000)
        run(3, 1);
        rdchk(OFF_KNOWN, 32'h0);
        rdchk(OFF_FLAGS, 32'h0);
        run(300, 0);
        apb(1, OFF_CTRL, 32'h0, rd, er);
        en = 0;
        run(20, 0);
        apb(1, OFF_CTRL, 32'h1, rd, er);
        en = 1;
        run(100, 0);
        wrap_up();
    end
endmodule // tb_top
